/* bench/tcn_cmp_model.sv */
`timescale 1ns/1ps
module tcn_cmp_model (
    input wire logic ref_clk,
    input wire logic fire,
    output logic cmpMatch
);
    initial cmpMatch = 1'b0;
    // one-cycle trigger on the system clock
    always @(posedge ref_clk) cmpMatch <= fire;
endmodule : tcn_cmp_model

/* bench/tcn_timer_bench.sv */
`timescale 1ns/1ps
module tcn_timer_bench
    import tcn_pkg::*;
;
    logic ref_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, fire = 1'b0;
    logic adcEnable = 1'b0, sleepMode = 1'b0, cmpMatch, avs_waitrequest, overflowIrq, adcStart, oscLowDrive, seen;
    logic [5:0] avs_address = 6'h00;
    logic extClk = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0] avs_byteenable = 4'h0;
    logic [8:0] expQ[$];
    logic [8:0] e;
    logic [7:0] lastRd;
    logic [15:0] rnd = 16'hC57;
    int fails = 0, cmp_count = 0, cyc = 0, i;
    always #10 ref_clk = ~ref_clk;
    tcn_timer tcn_timer_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .extClk(extClk), .cmpMatch(cmpMatch),
        .adcEnable(adcEnable), .sysclkFromOsc(1'b0), .sleepMode(sleepMode), .overflowIrq(overflowIrq),
        .adcStart(adcStart), .oscEnable(), .oscLowDrive(oscLowDrive), .cmpEqual());
    tcn_cmp_model tcn_cmp_model_i (.ref_clk(ref_clk), .fire(fire), .cmpMatch(cmpMatch));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic check(input string n, input logic [7:0] x, input logic [7:0] s);
        cmp_count++;
        if (s !== x) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask : check
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be,
        input logic [8:0] x);
        @(posedge ref_clk);
        if (!wr) expQ.push_back(x);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        if (!wr) lastRd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 4'h1, 9'h0);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] x);
        bus(1'b0, a, 32'h0, 4'h1, {1'b1, x});
    endtask : rd
    // reads are judged when they complete
    always @(posedge ref_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            e = expQ.pop_front();
            if (e[8]) check("readdata", e[7:0], avs_readdata[7:0]);
        end
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(6'h08, 8'h00);
        rd(6'h0C, 8'h00);
        for (i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            wr(6'h00, rnd[7:0]);
            wr(6'h04, rnd[15:8]);
            rd(6'h00, rnd[7:0]);
            rd(6'h04, rnd[15:8]);
        end
        wr(6'h08, 8'h80);
        wr(6'h04, 8'hAB);
        rd(6'h00, rnd[7:0]);
        rd(6'h04, rnd[15:8]);
        wr(6'h04, 8'h56);
        wr(6'h00, 8'h78);
        wr(6'h08, 8'h00);
        rd(6'h04, 8'h56);
        rd(6'h00, 8'h78);
        wr(6'h04, 8'hFF);
        wr(6'h00, 8'hFE);
        wr(6'h10, 8'h01);
        wr(6'h08, 8'h01);
        i = 0;
        do begin
            bus(1'b0, 6'h0C, 32'h0, 4'h1, 9'h0);
            i++;
        end while (lastRd[0] !== 1'b1 && i < 40);
        check("flag", 8'h01, lastRd);
        check("overflowIrq", 8'h01, {7'h0, overflowIrq});
        rd(6'h04, 8'h00);
        wr(6'h10, 8'h00);
        repeat (3) @(posedge ref_clk);
        check("overflowIrq", 8'h00, {7'h0, overflowIrq});
        wr(6'h0C, 8'h00);
        rd(6'h0C, 8'h00);
        wr(6'h1C, 8'h0B);
        adcEnable <= 1'b1;
        wr(6'h04, 8'h10);
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
        seen = 1'b0;
        repeat (6) begin
            @(negedge ref_clk);
            seen = seen | adcStart;
        end
        check("adcStart", 8'h01, {7'h0, seen});
        wr(6'h08, 8'h00);
        rd(6'h04, 8'h00);
        rd(6'h0C, 8'h00);
        bus(1'b1, 6'h10, 32'h0, 4'h4, 9'h0);
        sleepMode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("oscLowDrive", 8'h01, {7'h0, oscLowDrive});
        sleepMode <= 1'b0;
        wr(6'h04, 8'h80);
        wr(6'h00, 8'h00);
        wr(6'h08, 8'h0F);
        repeat (3) begin
            extClk <= 1'b1;
            repeat (2) @(posedge ref_clk);
            extClk <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        wr(6'h08, 8'h0E);
        rd(6'h08, 8'h0E);
        rd(6'h00, 8'h03);
        rd(6'h04, 8'h80);
        rd(6'h20, 8'h00);
        finish_test();
    end
endmodule : tcn_timer_bench

/* bench/tcn_timer_monitor.sv */
`timescale 1ns/1ps
module tcn_timer_monitor
    import tcn_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic cmpMatch,
    input wire logic adcEnable,
    input wire logic sysclkFromOsc,
    input wire logic sleepMode,
    input wire logic overflowIrq,
    input wire logic adcStart,
    input wire logic oscEnable,
    input wire logic oscLowDrive
);
    logic ackW;
    logic ackR;
    assign ackW = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign ackR = avs_read && !avs_waitrequest;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one wait cycle");
    unmapped_zero_a: assert property (ackR && avs_address[5] |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    irq_mask_a: assert property (ackW && avs_address == 6'h10 && !avs_writedata[0] |-> ##[1:3] !overflowIrq)
        else $error("irq not masked");
    flag_clear_a: assert property (ackW && avs_address == 6'h0C && !avs_writedata[0] |-> ##[1:3] !overflowIrq)
        else $error("flag clear ignored");
    adc_cause_a: assert property (adcStart |-> $past(cmpMatch) && $past(adcEnable))
        else $error("conversion start without trigger");
    low_drive_a: assert property (oscLowDrive |-> $past(sleepMode))
        else $error("low drive outside sleep");
    osc_follow_a: assert property ($changed(oscEnable) |-> $past(ackW && avs_address == 6'h08)
        || $past(ackW && avs_address == 6'h08, 2)) else $error("oscillator enable moved alone");
    run_status_a: assert property (ackR && avs_address == 6'h08 |-> avs_readdata[6] == sysclkFromOsc)
        else $error("clock status bit wrong");
endmodule : tcn_timer_monitor
bind tcn_timer tcn_timer_monitor tcn_timer_monitor_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmpMatch(cmpMatch), .adcEnable(adcEnable), .sysclkFromOsc(sysclkFromOsc), .sleepMode(sleepMode),
    .overflowIrq(overflowIrq), .adcStart(adcStart), .oscEnable(oscEnable), .oscLowDrive(oscLowDrive));

/* hdl/tcn_pkg.sv */
package tcn_pkg;
    typedef struct packed {
        logic wide;
        logic [1:0] prescale;
        logic oscEn;
        logic noSync;
        logic srcSel;
        logic timerOn;
    } tcn_ctrl_t;
    typedef struct packed {
        logic [3:0] mode;
        logic [15:0] value;
    } tcn_cmp_t;
    typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} tcn_bus_t;
endpackage : tcn_pkg

/* hdl/tcn_regs.svh */
`ifndef TCN_REGS_SVH
`define TCN_REGS_SVH
`define TCN_OFF_CNT_LO 4'h0
`define TCN_OFF_CNT_HI 4'h4
`define TCN_OFF_CTRL 4'h8
`define TCN_OFF_FLAG 4'hC
`define TCN_ADR_W 4
`define TCN_OFF_ENA 4'h0
`define TCN_OFF_CMPLO 4'h4
`define TCN_OFF_CMPHI 4'h8
`define TCN_OFF_CMPMODE 4'hC
`define TCN_OFF_CFG 4'h0
`define TCN_BIT_ON 0
`define TCN_BIT_CS 1
`define TCN_BIT_NOSYNC 2
`define TCN_BIT_OSCEN 3
`define TCN_BIT_PS_LO 4
`define TCN_BIT_RUN 6
`define TCN_BIT_WIDE 7
`define TCN_BIT_OVF 0
`define TCN_BIT_LPOSC 5
`define TCN_CTRL_RST 8'h00
`define TCN_CFG_RST 8'hFF
`define TCN_TRIG_CODE 4'hB
`define TCN_CNT_MAX 16'hFFFF
`endif

/* hdl/tcn_timer.sv */
// Operation
// - counter counts up 0000h to FFFFh then wraps to zero
// - wrap from all ones sets overflow flag, flag register bit 0
// - interrupt request passes only while enable register bit 0 set
// - trigger code 1011 resets counter, starts conversion if converter enabled
// - trigger reset never sets overflow flag
// - trigger reset guaranteed only in timer or synchronized counter mode
// - low byte counter write in trigger cycle wins; trigger's counter reset dropped, conversion start kept
// - compare value pair acts as period in trigger mode; here a match only drives cmpEqual, counter reset comes from cmpMatch
// - wide mode maps high byte address to buffer
// - wide mode low byte read copies live high into buffer
// - wide mode low byte write loads live high from buffer
// - wide mode gives no direct path to live high byte
// - low byte write clears prescaler; high writes do not
// - clearing low power config bit 5 reduces oscillator drive in sleep
// - prescale 00,01,10,11 divides by 1,2,4,8
// - source clear counts per instruction cycle, set on external rising edge
// - external clock synchronized when sync disable is 0
// - counts only while timer on bit 0 set
`timescale 1ns/1ps
`include "tcn_regs.svh"
module tcn_timer
    import tcn_pkg::*;
#(
    parameter int INSTR_DIV = 4
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [`TCN_ADR_W+1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic extClk,
    input wire logic cmpMatch,
    input wire logic adcEnable,
    input wire logic sysclkFromOsc,
    input wire logic sleepMode,
    output logic overflowIrq,
    output logic adcStart,
    output logic oscEnable,
    output logic oscLowDrive,
    output logic cmpEqual
);
    initial begin
        if (INSTR_DIV < 1 || INSTR_DIV > 255) $error("INSTR_DIV out of range");
    end
    // bank 0: timer regs, bank 1: enable/compare/config
    logic bank;
    logic [`TCN_ADR_W-1:0] offs;
    assign bank = avs_address[`TCN_ADR_W];
    assign offs = avs_address[`TCN_ADR_W-1:0];
    logic [7:0] wByte;
    assign wByte = avs_writedata[7:0];
    logic wLane;
    assign wLane = avs_byteenable[0];
    // top address bit set: unmapped, reads zero, writes dropped
    logic mapped;
    assign mapped = !avs_address[`TCN_ADR_W+1];
    logic [7:0] ctrlRst;
    assign ctrlRst = `TCN_CTRL_RST;

    tcn_ctrl_t ctrl_q, ctrl_d;
    tcn_cmp_t cmp_q, cmp_d;
    logic [15:0] cnt_q, cnt_d;
    logic [7:0] hiBuf_q, hiBuf_d;
    logic [2:0] pre_q, pre_d;
    logic [7:0] div_q, div_d;
    logic [2:0] ext_q, ext_d;
    logic ovf_q, ovf_d, ena_q, ena_d, lpCfg_q, lpCfg_d;
    logic trigPend_q, trigPend_d, irq_q, irq_d, adc_q, adc_d, eq_q, eq_d;
    logic [31:0] rd_q, rd_d;
    tcn_bus_t bus_q, bus_d;
    logic waitReq_q, waitReq_d;

    logic acc, wrLo, wrHi, rdLo, tick, preDone, trigMode, trigHit, extRise, srcEdge;
    assign acc = (avs_read | avs_write) && bus_q == BUS_IDLE;
    assign wrLo = acc && mapped && avs_write && wLane && !bank && offs == `TCN_OFF_CNT_LO;
    assign wrHi = acc && mapped && avs_write && wLane && !bank && offs == `TCN_OFF_CNT_HI;
    assign rdLo = acc && mapped && avs_read && !bank && offs == `TCN_OFF_CNT_LO;
    assign trigMode = cmp_q.mode == `TCN_TRIG_CODE;
    assign trigHit = trigMode && cmpMatch;

    always_comb begin
        ext_d = {ext_q[1:0], extClk};
    end
    // ext_q[1] is the synchronized level; ext_q[2] its last value
    assign extRise = ext_q[1] && !ext_q[2];
    // unsynchronized mode still uses the sync chain here; in this single-clock
    // build only the synchronized path exists, which permits for the trigger
    always_comb begin
        div_d = (div_q == 8'(INSTR_DIV - 1)) ? 8'h00 : div_q + 8'h01;
        srcEdge = ctrl_q.srcSel ? extRise : (div_q == 8'h00);
    end
    assign tick = ctrl_q.timerOn && srcEdge;
    assign preDone = (pre_q & ((3'h1 << ctrl_q.prescale) - 3'h1)) == ((3'h1 << ctrl_q.prescale) - 3'h1);

    always_comb begin
        cnt_d = cnt_q;
        hiBuf_d = hiBuf_q;
        pre_d = pre_q;
        ovf_d = ovf_q;
        trigPend_d = trigPend_q | trigHit;
        adc_d = trigHit && adcEnable;
        if (tick) begin
            pre_d = preDone ? 3'h0 : pre_q + 3'h1;
            if (preDone) begin
                if (trigPend_q) begin
                    cnt_d = 16'h0000;
                    trigPend_d = trigHit;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_q == `TCN_CNT_MAX) ovf_d = 1'b1;
                end
            end
        end
        if (acc && mapped && avs_write && wLane && bank == 1'b0 && offs == `TCN_OFF_FLAG && !wByte[`TCN_BIT_OVF])
            ovf_d = ovf_d & (tick && preDone && !trigPend_q && cnt_q == `TCN_CNT_MAX);
        if (rdLo && ctrl_q.wide) hiBuf_d = cnt_q[15:8];
        if (wrHi) begin
            if (ctrl_q.wide) hiBuf_d = wByte;
            else cnt_d[15:8] = wByte;
        end
        if (wrLo) begin
            cnt_d[7:0] = wByte;
            if (ctrl_q.wide) cnt_d[15:8] = hiBuf_q;
            pre_d = 3'h0;
            trigPend_d = 1'b0;
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        cmp_d = cmp_q;
        ena_d = ena_q;
        lpCfg_d = lpCfg_q;
        if (acc && mapped && avs_write && wLane) begin
            if (!bank && offs == `TCN_OFF_CTRL) ctrl_d = tcn_ctrl_t'({wByte[7], wByte[5:0]});
            if (bank) begin
                case (offs)
                    `TCN_OFF_ENA: ena_d = wByte[0];
                    `TCN_OFF_CMPLO: cmp_d.value[7:0] = wByte;
                    `TCN_OFF_CMPHI: cmp_d.value[15:8] = wByte;
                    `TCN_OFF_CMPMODE: cmp_d.mode = wByte[3:0];
                    default: lpCfg_d = lpCfg_q;
                endcase
            end
        end
        if (acc && mapped && avs_write && avs_byteenable[2] && bank && offs == `TCN_OFF_CFG)
            lpCfg_d = avs_writedata[16 + `TCN_BIT_LPOSC];
        irq_d = ovf_d && ena_d;
        eq_d = trigMode && cnt_q == cmp_q.value;
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        bus_d = acc ? BUS_ACK : BUS_IDLE;
        // exactly one wait cycle: low in the cycle after the request is taken
        waitReq_d = !acc;
        if (acc && avs_read && mapped) begin
            if (!bank) begin
                case (offs)
                    `TCN_OFF_CNT_LO: rd_d[7:0] = cnt_q[7:0];
                    `TCN_OFF_CNT_HI: rd_d[7:0] = ctrl_q.wide ? hiBuf_q : cnt_q[15:8];
                    `TCN_OFF_CTRL: rd_d[7:0] = {ctrl_q.wide, sysclkFromOsc, ctrl_q.prescale, ctrl_q.oscEn,
                                                ctrl_q.noSync, ctrl_q.srcSel, ctrl_q.timerOn};
                    `TCN_OFF_FLAG: rd_d[`TCN_BIT_OVF] = ovf_q;
                    default: rd_d = 32'h0000_0000;
                endcase
            end else begin
                case (offs)
                    `TCN_OFF_ENA: rd_d[0] = ena_q;
                    `TCN_OFF_CMPLO: rd_d[7:0] = cmp_q.value[7:0];
                    `TCN_OFF_CMPHI: rd_d[7:0] = cmp_q.value[15:8];
                    `TCN_OFF_CMPMODE: rd_d[3:0] = cmp_q.mode;
                    default: rd_d = 32'h0000_0000;
                endcase
            end
        end
        if (acc && avs_read && mapped && bank && offs == `TCN_OFF_CFG)
            rd_d[16 + `TCN_BIT_LPOSC] = lpCfg_q;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_q <= tcn_ctrl_t'({ctrlRst[7], ctrlRst[5:0]});
            cmp_q <= '0;
            cnt_q <= 16'h0000;
            hiBuf_q <= 8'h00;
            pre_q <= 3'h0;
            div_q <= 8'h00;
            ext_q <= 3'h0;
            ovf_q <= 1'b0;
            ena_q <= 1'b0;
            lpCfg_q <= 1'b1;
            trigPend_q <= 1'b0;
            irq_q <= 1'b0;
            adc_q <= 1'b0;
            eq_q <= 1'b0;
            rd_q <= 32'h0000_0000;
            bus_q <= BUS_IDLE;
            waitReq_q <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            cmp_q <= cmp_d;
            cnt_q <= cnt_d;
            hiBuf_q <= hiBuf_d;
            pre_q <= pre_d;
            div_q <= div_d;
            ext_q <= ext_d;
            ovf_q <= ovf_d;
            ena_q <= ena_d;
            lpCfg_q <= lpCfg_d;
            trigPend_q <= trigPend_d;
            irq_q <= irq_d;
            adc_q <= adc_d;
            eq_q <= eq_d;
            rd_q <= rd_d;
            bus_q <= bus_d;
            waitReq_q <= waitReq_d;
        end
    end

    logic oscEn_q, lowDrv_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            oscEn_q <= 1'b0;
            lowDrv_q <= 1'b0;
        end else begin
            oscEn_q <= ctrl_q.oscEn;
            lowDrv_q <= !lpCfg_q && sleepMode;
        end
    end

    assign avs_readdata = rd_q;
    assign avs_waitrequest = waitReq_q;
    assign overflowIrq = irq_q;
    assign adcStart = adc_q;
    assign oscEnable = oscEn_q;
    assign oscLowDrive = lowDrv_q;
    assign cmpEqual = eq_q;
endmodule : tcn_timer
